// File: hdl/icsd_ctl.v
// Input clock select and divider clock gating control, top level.
// Assumes a synchronous byte-wide register port from the serial host
// interface and alarm inputs synchronous to core_clk_in.
`timescale 1ns/1ps
`include "icsd_consts.vh"

module icsd_ctl (
  input  wire        core_clk_in,
  input  wire        rst_n_in,
  input  wire        clk_en_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [11:0] reg_addr_in,
  input  wire [7:0]  reg_wdata_in,
  input  wire [1:0]  signal_loss_alarm_in,
  input  wire [1:0]  out_of_freq_alarm_in,
  input  wire        pin_select_in,
  output reg  [7:0]  reg_rdata_out,
  output reg         holdover_out,
  output reg         active_input_out,
  output reg         hitless_enable_out,
  output reg         ext_reference_sel_out,
  output reg         io_voltage_sel_out,
  output reg  [1:0]  input_buf_en_out,
  output reg  [1:0]  pulsed_cmos_out,
  output reg  [1:0]  out_divider_route_out,
  output reg  [1:0]  out_divider_int_mode_out,
  output reg  [1:0]  out_divider_power_out,
  output reg  [3:0]  pre_divider_clk_off_out,
  output reg         feedback_divider_clk_off_out,
  output reg  [1:0]  out_divider_clk_off_out
);

  // ******************************************************************
  // Register storage
  // ******************************************************************
  reg       force_hold;
  reg [1:0] switch_mode_sel;
  reg       hitless_enable;
  reg [3:0] signal_loss_mask;
  reg [3:0] freq_alarm_mask;
  reg [2:0] input0_rank;
  reg [2:0] input1_rank;
  reg       select_by_register;
  reg       register_select;
  reg       ext_reference_sel;
  reg       io_voltage_sel;
  reg [1:0] input_buf_en;
  reg [1:0] pulsed_cmos;
  reg [1:0] out_divider_route;
  reg [1:0] out_divider_int_mode;
  reg [1:0] out_divider_power;
  reg [3:0] pre_divider_clk_off;
  reg       feedback_divider_clk_off;
  reg [1:0] out_divider_clk_off;

  // Selection state.
  reg       active_input;
  reg       in_holdover;
  reg       next_active;
  reg       next_holdover;
  reg [7:0] next_rdata;

  wire      wr_sel;
  wire      any_avail;
  wire      best_input;
  wire [1:0] avail;
  wire [3:0] slot;

  // Register slots: one binary code per mapped address, so the read and
  // write decoders cannot drift apart when an address is added.
  localparam [3:0] SLOT_NONE    = 4'h0;
  localparam [3:0] SLOT_SEL     = 4'h1;
  localparam [3:0] SLOT_STATUS  = 4'h2;
  localparam [3:0] SLOT_HOLD    = 4'h3;
  localparam [3:0] SLOT_SWITCH  = 4'h4;
  localparam [3:0] SLOT_MASKS   = 4'h5;
  localparam [3:0] SLOT_RANKS   = 4'h6;
  localparam [3:0] SLOT_REFSRC  = 4'h7;
  localparam [3:0] SLOT_IOVSEL  = 4'h8;
  localparam [3:0] SLOT_INBUF   = 4'h9;
  localparam [3:0] SLOT_ROUTE   = 4'ha;
  localparam [3:0] SLOT_INTMODE = 4'hb;
  localparam [3:0] SLOT_POWER   = 4'hc;
  localparam [3:0] SLOT_FRACOFF = 4'hd;
  localparam [3:0] SLOT_NCLKOFF = 4'he;

  // Checks a rank field against the selectable range.
  function rank_ok;
    input [2:0] rank;
    begin
      rank_ok = (rank != `ICSD_RANK_OFF) && (rank <= `ICSD_RANK_MAX);
    end
  endfunction

  // Maps a register address to its slot. Unmapped addresses give
  // SLOT_NONE, which reads back as zero and swallows writes.
  function [3:0] reg_slot;
    input [11:0] addr;
    begin
      case (addr)
        `ICSD_A_SEL:     reg_slot = SLOT_SEL;
        `ICSD_A_STATUS:  reg_slot = SLOT_STATUS;
        `ICSD_A_HOLD:    reg_slot = SLOT_HOLD;
        `ICSD_A_SWITCH:  reg_slot = SLOT_SWITCH;
        `ICSD_A_MASKS:   reg_slot = SLOT_MASKS;
        `ICSD_A_RANKS:   reg_slot = SLOT_RANKS;
        `ICSD_A_REFSRC:  reg_slot = SLOT_REFSRC;
        `ICSD_A_IOVSEL:  reg_slot = SLOT_IOVSEL;
        `ICSD_A_INBUF:   reg_slot = SLOT_INBUF;
        `ICSD_A_ROUTE:   reg_slot = SLOT_ROUTE;
        `ICSD_A_INTMODE: reg_slot = SLOT_INTMODE;
        `ICSD_A_POWER:   reg_slot = SLOT_POWER;
        `ICSD_A_FRACOFF: reg_slot = SLOT_FRACOFF;
        `ICSD_A_NCLKOFF: reg_slot = SLOT_NCLKOFF;
        default:         reg_slot = SLOT_NONE;
      endcase
    end
  endfunction

  // ******************************************************************
  // Availability of each input
  // ******************************************************************
  // An input counts only while enabled, ranked and free of unmasked
  // alarms. Reserved ranks are treated as not selectable so in the automatic
  // modes a bad write can never steer the loop onto an unranked input.
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_avail
      wire loss_seen = signal_loss_alarm_in[g] & ~signal_loss_mask[g];
      wire freq_seen = out_of_freq_alarm_in[g] & ~freq_alarm_mask[g];
      wire [2:0] rank = (g == 0) ? input0_rank : input1_rank;
      assign avail[g] = input_buf_en[g] & rank_ok(rank) &
                        ~loss_seen & ~freq_seen;
    end
  endgenerate

  icsd_select u_select (
    .avail_in (avail),
    .rank0_in (input0_rank),
    .rank1_in (input1_rank),
    .any_out  (any_avail),
    .best_out (best_input)
  );

  // ******************************************************************
  // Selection decision
  // ******************************************************************
  // Manual choice comes from a pin or a register bit; automatic modes rank
  // the inputs. Reserved mode 3 is handled like manual as a safe default.
  always @* begin
    next_active   = active_input;
    next_holdover = 1'b0;
    case (switch_mode_sel)
      `ICSD_MODE_NONREV: begin
        // Stay while the current input is still usable.
        if (!avail[active_input]) begin
          next_active = best_input;
        end
        next_holdover = ~any_avail;
      end
      `ICSD_MODE_REV: begin
        next_active   = best_input;
        next_holdover = ~any_avail;
      end
      default: begin
        next_active = select_by_register ? register_select
                                         : pin_select_in;
      end
    endcase
    // Holdover from automatic mode keeps the last choice for history.
    if (next_holdover) begin
      next_active = active_input;
    end
    if (force_hold) begin
      next_holdover = 1'b1;
      next_active   = active_input;
    end
  end

  // ******************************************************************
  // Read data decode
  // ******************************************************************
  always @* begin
    next_rdata = `ICSD_RESET_BYTE;
    case (slot)
      SLOT_STATUS:  next_rdata = {1'b0, active_input,
                                  6'h00};
      SLOT_SEL:     next_rdata = {6'h00, register_select,
                                  select_by_register};
      SLOT_HOLD:    next_rdata = {7'h00, force_hold};
      SLOT_SWITCH:  next_rdata = {5'h00, hitless_enable,
                                  switch_mode_sel};
      SLOT_MASKS:   next_rdata = {freq_alarm_mask, signal_loss_mask};
      SLOT_RANKS:   next_rdata = {1'b0, input1_rank, 1'b0, input0_rank};
      SLOT_REFSRC:  next_rdata = {7'h00, ext_reference_sel};
      SLOT_IOVSEL:  next_rdata = {7'h00, io_voltage_sel};
      SLOT_INBUF:   next_rdata = {2'h0, pulsed_cmos, 2'h0, input_buf_en};
      SLOT_ROUTE:   next_rdata = {6'h00, out_divider_route};
      SLOT_INTMODE: next_rdata = {6'h00, out_divider_int_mode};
      SLOT_POWER:   next_rdata = {6'h00, out_divider_power};
      SLOT_FRACOFF: next_rdata = {2'h0, feedback_divider_clk_off, 1'b0,
                                  pre_divider_clk_off};
      SLOT_NCLKOFF: next_rdata = {6'h00, out_divider_clk_off};
      default:         next_rdata = `ICSD_RESET_BYTE;
    endcase
  end

  // One address decode feeds both the read mux and the write strobes.
  assign slot   = reg_slot(reg_addr_in);
  assign wr_sel = clk_en_in & reg_wr_in;

  // ******************************************************************
  // Register writes
  // ******************************************************************
  // Reserved bits are dropped on write and read back as zero.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      force_hold               <= 1'b0;
      switch_mode_sel          <= `ICSD_MODE_MAN;
      hitless_enable           <= 1'b0;
      signal_loss_mask         <= 4'h0;
      freq_alarm_mask          <= 4'h0;
      input0_rank              <= 3'h0;
      input1_rank              <= 3'h0;
      select_by_register       <= 1'b0;
      register_select          <= 1'b0;
      ext_reference_sel        <= 1'b0;
      io_voltage_sel           <= 1'b0;
      input_buf_en             <= 2'h0;
      pulsed_cmos              <= 2'h0;
      out_divider_route        <= 2'h0;
      out_divider_int_mode     <= 2'h0;
      out_divider_power        <= 2'h0;
      pre_divider_clk_off      <= 4'h0;
      feedback_divider_clk_off <= 1'b0;
      out_divider_clk_off      <= 2'h0;
    end else if (wr_sel) begin
      case (slot)
        SLOT_SEL: begin
          select_by_register <= reg_wdata_in[`ICSD_FIELD_LO];
          register_select    <= reg_wdata_in[`ICSD_INSEL_BIT];
        end
        SLOT_HOLD: begin
          force_hold <= reg_wdata_in[`ICSD_FIELD_LO];
        end
        SLOT_SWITCH: begin
          switch_mode_sel <= reg_wdata_in[`ICSD_PAIR_HI:`ICSD_FIELD_LO];
          hitless_enable  <= reg_wdata_in[`ICSD_HSW_BIT];
        end
        SLOT_MASKS: begin
          signal_loss_mask <= reg_wdata_in[`ICSD_NIBBLE_HI:`ICSD_FIELD_LO];
          freq_alarm_mask  <= reg_wdata_in[`ICSD_OOF_LO+3:`ICSD_OOF_LO];
        end
        SLOT_RANKS: begin
          input0_rank <= reg_wdata_in[`ICSD_RANK0_LO+2:`ICSD_RANK0_LO];
          input1_rank <= reg_wdata_in[`ICSD_RANK1_LO+2:`ICSD_RANK1_LO];
        end
        SLOT_REFSRC: begin
          ext_reference_sel <= reg_wdata_in[`ICSD_FIELD_LO];
        end
        SLOT_IOVSEL: begin
          io_voltage_sel <= reg_wdata_in[`ICSD_FIELD_LO];
        end
        SLOT_INBUF: begin
          input_buf_en <= reg_wdata_in[`ICSD_PAIR_HI:`ICSD_FIELD_LO];
          pulsed_cmos  <= reg_wdata_in[`ICSD_PCMOS_LO+1:`ICSD_PCMOS_LO];
        end
        SLOT_ROUTE: begin
          out_divider_route <= reg_wdata_in[`ICSD_PAIR_HI:`ICSD_FIELD_LO];
        end
        SLOT_INTMODE: begin
          out_divider_int_mode <= reg_wdata_in[`ICSD_PAIR_HI:`ICSD_FIELD_LO];
        end
        SLOT_POWER: begin
          out_divider_power <= reg_wdata_in[`ICSD_PAIR_HI:`ICSD_FIELD_LO];
        end
        SLOT_FRACOFF: begin
          pre_divider_clk_off      <=
            reg_wdata_in[`ICSD_NIBBLE_HI:`ICSD_FIELD_LO];
          feedback_divider_clk_off <= reg_wdata_in[`ICSD_FB_OFF_BIT];
        end
        SLOT_NCLKOFF: begin
          out_divider_clk_off <= reg_wdata_in[`ICSD_PAIR_HI:`ICSD_FIELD_LO];
        end
        default: begin
          force_hold <= force_hold;
        end
      endcase
    end
  end

  // ******************************************************************
  // Selection state and read data
  // ******************************************************************
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_input  <= 1'b0;
      in_holdover   <= 1'b0;
      reg_rdata_out <= `ICSD_RESET_BYTE;
    end else if (clk_en_in) begin
      active_input <= next_active;
      in_holdover  <= next_holdover;
      if (reg_rd_in) begin
        reg_rdata_out <= next_rdata;
      end
    end
  end

  // ******************************************************************
  // Control outputs
  // ******************************************************************
  // Outputs are registered copies, the route bits gated by the power bits, so
  // every pin leaves a flip-flop; they trail the stored fields by one enabled cycle.
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      holdover_out                 <= 1'b0;
      active_input_out             <= 1'b0;
      hitless_enable_out           <= 1'b0;
      ext_reference_sel_out        <= 1'b0;
      io_voltage_sel_out           <= 1'b0;
      input_buf_en_out             <= 2'h0;
      pulsed_cmos_out              <= 2'h0;
      out_divider_route_out        <= 2'h0;
      out_divider_int_mode_out     <= 2'h0;
      out_divider_power_out        <= 2'h0;
      pre_divider_clk_off_out      <= 4'h0;
      feedback_divider_clk_off_out <= 1'b0;
      out_divider_clk_off_out      <= 2'h0;
    end else if (clk_en_in) begin
      holdover_out             <= in_holdover;
      active_input_out         <= active_input;
      hitless_enable_out       <= hitless_enable;
      ext_reference_sel_out    <= ext_reference_sel;
      io_voltage_sel_out       <= io_voltage_sel;
      input_buf_en_out         <= input_buf_en;
      pulsed_cmos_out          <= pulsed_cmos;
      // A divider only reaches the driver muxes while powered.
      out_divider_route_out    <= out_divider_route &
                                  out_divider_power;
      out_divider_int_mode_out <= out_divider_int_mode;
      out_divider_power_out    <= out_divider_power;
      pre_divider_clk_off_out  <= pre_divider_clk_off;
      feedback_divider_clk_off_out <= feedback_divider_clk_off;
      out_divider_clk_off_out  <= out_divider_clk_off;
    end
  end

endmodule

// File: hdl/icsd_consts.vh
// Constants for the input clock select and divider control block.
// Assumes a byte-wide register port with a 12-bit address from the host
// interface; the file holds definitions only.
//
// How it works
// - Force-holdover bit set forces holdover whatever the inputs do.
// - Mode: 0 manual, 1 auto non-revertive, 2 auto revertive, 3 reserved.
// - Hitless enable: 0 glitchless without phase buildout, 1 hitless with it.
// - Loss mask bit per input hides that alarm from selection when set.
// - Frequency mask bit per input hides that alarm from selection when set.
// - Rank per input: 0 unselectable, 1 and 2 ranked, 3 to 7 reserved.
// - Automatic mode picks the available input with the lowest rank value; non-revertive mode keeps the current input while it stays available.
// - Equal ranks are broken in favour of input 0 over input 1.
// - Reference source bit: 0 crystal, 1 external clock on the crystal pins.
// - Input enable bit per input; cleared bit powers down that input buffer.
// - Pulsed format bit per input: 0 standard, 1 pulsed CMOS.
// - Routing bit per output divider steers its clock to the driver muxes while that divider's power bit is set.
// - Integer mode bit per output divider: 0 fractional, 1 integer.
// - Bits 3:0 gate off the input fractional pre-divider clocks when set.
// - Bit 5 of the fractional disable register stops the feedback clock.
// - Manual mode takes the selection from pins or from a register bit.
// - Read-only status reports the currently selected input, 0 or 1.
`ifndef ICSD_CONSTS_VH
`define ICSD_CONSTS_VH

// ********************************************************************
// Register offsets
// ********************************************************************
`define ICSD_A_SEL      12'h52a
`define ICSD_A_STATUS   12'h507
`define ICSD_A_HOLD     12'h535
`define ICSD_A_SWITCH   12'h536
`define ICSD_A_MASKS    12'h537
`define ICSD_A_RANKS    12'h538
`define ICSD_A_REFSRC   12'h90e
`define ICSD_A_IOVSEL   12'h943
`define ICSD_A_INBUF    12'h949
`define ICSD_A_ROUTE    12'ha03
`define ICSD_A_INTMODE  12'ha04
`define ICSD_A_POWER    12'ha05
`define ICSD_A_FRACOFF  12'hb44
`define ICSD_A_NCLKOFF  12'hb4a

// ********************************************************************
// Field positions and encodings
// ********************************************************************
`define ICSD_MODE_MAN     2'h0
`define ICSD_MODE_NONREV  2'h1
`define ICSD_MODE_REV     2'h2
`define ICSD_RANK0_LO     0
`define ICSD_RANK1_LO     4
`define ICSD_RANK_OFF     3'h0
`define ICSD_RANK_MAX     3'h2
`define ICSD_STATUS_LO    6
`define ICSD_HSW_BIT      2
`define ICSD_OOF_LO       4
`define ICSD_PCMOS_LO     4
`define ICSD_FB_OFF_BIT   5
`define ICSD_RESET_BYTE   8'h00
`define ICSD_FIELD_LO     0
`define ICSD_INSEL_BIT    1
`define ICSD_PAIR_HI      1
`define ICSD_NIBBLE_HI    3

`endif

// File: hdl/icsd_select.v
// Automatic input choice: combinational ranking of the two inputs.
// Assumes alarm and rank inputs are steady in the clock domain of its user.
`timescale 1ns/1ps
`include "icsd_consts.vh"

module icsd_select (
  input  wire [1:0] avail_in,
  input  wire [2:0] rank0_in,
  input  wire [2:0] rank1_in,
  output reg        any_out,
  output reg        best_out
);

  // Pick the lowest rank among available inputs; ties go to input 0.
  always @* begin
    any_out  = |avail_in;
    best_out = 1'b0;
    if (avail_in == 2'b10) begin
      best_out = 1'b1;
    end else if (avail_in == 2'b11 && rank1_in < rank0_in) begin
      best_out = 1'b1; // Strict less-than keeps input 0 on a tie.
    end
  end

endmodule

// File: sim/icsd_chk_assertions.sv
// Concurrent checks on the register port and field outputs of icsd_ctl.
// Assumes it is bound to icsd_ctl and clocked by the 50 MHz core clock.
`timescale 1ns/1ps
`include "icsd_consts.vh"

module icsd_chk (
  input wire        core_clk_in,
  input wire        rst_n_in,
  input wire        clk_en_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [11:0] reg_addr_in,
  input wire [7:0]  reg_wdata_in,
  input wire [7:0]  reg_rdata_out,
  input wire        holdover_out,
  input wire        hitless_enable_out,
  input wire [1:0]  input_buf_en_out,
  input wire [1:0]  pulsed_cmos_out,
  input wire [1:0]  out_divider_route_out,
  input wire [1:0]  out_divider_power_out,
  input wire [3:0]  pre_divider_clk_off_out
);
  // ********************************************
  // Properties
  // ********************************************
  // Reset wipes every history, so all checks pause while it is low.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_rdata_held: assert property (!(clk_en_in && reg_rd_in)
    |=> $stable(reg_rdata_out)) else $error("read data moved");
  a_rank_spare: assert property (clk_en_in && reg_rd_in &&
    reg_addr_in == `ICSD_A_RANKS |=> (reg_rdata_out & 8'h88) == 8'h00)
    else $error("spare rank bits not zero");
  a_unmapped_zero: assert property (clk_en_in && reg_rd_in &&
    reg_addr_in == 12'h100 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_status_spare: assert property (clk_en_in && reg_rd_in &&
    reg_addr_in == `ICSD_A_STATUS |=> (reg_rdata_out & 8'hbf) == 8'h00)
    else $error("status spare bits not zero");
  a_force_hold: assert property (clk_en_in && reg_wr_in &&
    reg_addr_in == `ICSD_A_HOLD && reg_wdata_in[0] |-> ##[1:3] holdover_out)
    else $error("forced holdover missing");
  a_route_gated: assert property (
    (out_divider_route_out & ~out_divider_power_out) == 2'b00)
    else $error("route on for powered down divider");
  a_hitless_copy: assert property (clk_en_in && reg_wr_in &&
    reg_addr_in == `ICSD_A_SWITCH ##1 clk_en_in [*2]
    |-> hitless_enable_out == $past(reg_wdata_in[2], 2))
    else $error("hitless output wrong");
  a_predis_copy: assert property (clk_en_in && reg_wr_in &&
    reg_addr_in == `ICSD_A_FRACOFF ##1 clk_en_in [*2]
    |-> pre_divider_clk_off_out == $past(reg_wdata_in[3:0], 2))
    else $error("pre divider gate output wrong");
  a_inbuf_copy: assert property (clk_en_in && reg_wr_in &&
    reg_addr_in == `ICSD_A_INBUF ##1 clk_en_in [*2]
    |-> {input_buf_en_out, pulsed_cmos_out} ==
    {$past(reg_wdata_in[1:0], 2), $past(reg_wdata_in[5:4], 2)})
    else $error("input buffer outputs wrong");
endmodule

// File: sim/tb_top.sv
// Self-checking bench for icsd_ctl, driven through its register port.
// Assumes the constants header and the checker file are compiled first.
`timescale 1ns/1ps
`include "icsd_consts.vh"

module tb_top;
  logic        core_clk_in, rst_n_in, clk_en_in, reg_wr_in, reg_rd_in;
  logic        pin_select_in, holdover_out, active_input_out;
  logic        hitless_enable_out, ext_reference_sel_out;
  logic        io_voltage_sel_out, feedback_divider_clk_off_out;
  logic [11:0] reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out;
  logic [1:0]  signal_loss_alarm_in, out_of_freq_alarm_in;
  logic [1:0]  input_buf_en_out, pulsed_cmos_out, out_divider_route_out;
  logic [1:0]  out_divider_int_mode_out, out_divider_power_out;
  logic [1:0]  out_divider_clk_off_out;
  logic [3:0]  pre_divider_clk_off_out;
  int          n_mismatch, checks;
  // Writable registers and the bits each one keeps.
  logic [11:0] ra [12] = '{`ICSD_A_SEL, `ICSD_A_HOLD, `ICSD_A_SWITCH,
    `ICSD_A_MASKS, `ICSD_A_RANKS, `ICSD_A_REFSRC, `ICSD_A_IOVSEL,
    `ICSD_A_INBUF, `ICSD_A_ROUTE, `ICSD_A_INTMODE, `ICSD_A_POWER,
    `ICSD_A_FRACOFF};
  logic [7:0]  rm [12] = '{8'h03, 8'h01, 8'h07, 8'hff, 8'h77, 8'h01,
    8'h01, 8'h33, 8'h03, 8'h03, 8'h03, 8'h2f};

  icsd_ctl dut_u (.core_clk_in, .rst_n_in, .clk_en_in, .reg_wr_in,
    .reg_rd_in, .reg_addr_in, .reg_wdata_in, .signal_loss_alarm_in,
    .out_of_freq_alarm_in, .pin_select_in, .reg_rdata_out, .holdover_out,
    .active_input_out, .hitless_enable_out, .ext_reference_sel_out,
    .io_voltage_sel_out, .input_buf_en_out, .pulsed_cmos_out,
    .out_divider_route_out, .out_divider_int_mode_out,
    .out_divider_power_out, .pre_divider_clk_off_out,
    .feedback_divider_clk_off_out, .out_divider_clk_off_out);

  // ********************************************
  // Access and compare tasks
  // ********************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Idle edges after a write let the two-edge field latency settle.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge core_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    @(posedge core_clk_in);
    #1;
    chk(reg_rdata_out, e);
  endtask

  task automatic al(input logic [1:0] l, input logic [1:0] o);
    @(posedge core_clk_in);
    signal_loss_alarm_in <= l;
    out_of_freq_alarm_in <= o;
  endtask

  // Selection needs two edges to show; three gives a margin.
  task automatic sel(input logic a, input logic h);
    repeat (3) @(posedge core_clk_in);
    #1;
    chk({7'h00, active_input_out}, {7'h00, a});
    chk({7'h00, holdover_out}, {7'h00, h});
  endtask

  task automatic results;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ********************************************
  // Clock, watchdog and test sequence
  // ********************************************
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end

  // The sequence needs a few hundred cycles; this is a wide margin.
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_mismatch++;
    results();
  end

  initial begin
    {rst_n_in, reg_wr_in, reg_rd_in, pin_select_in} = 4'h0;
    clk_en_in = 1'b1;
    reg_addr_in = 12'h000;
    reg_wdata_in = 8'h00;
    signal_loss_alarm_in = 2'b00;
    out_of_freq_alarm_in = 2'b00;
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // Zero after reset, then only the defined bits survive all-ones.
    foreach (ra[i]) rd(ra[i], 8'h00);
    foreach (ra[i]) wr(ra[i], 8'hff);
    foreach (ra[i]) rd(ra[i], rm[i]);
    wr(`ICSD_A_NCLKOFF, 8'hff);
    rd(`ICSD_A_NCLKOFF, 8'h03);
    chk({input_buf_en_out, pulsed_cmos_out, out_divider_route_out,
      out_divider_int_mode_out}, 8'hff);
    chk({out_divider_power_out, out_divider_clk_off_out,
      pre_divider_clk_off_out}, 8'hff);
    chk({3'h0, hitless_enable_out, ext_reference_sel_out,
      io_voltage_sel_out, feedback_divider_clk_off_out, holdover_out},
      8'h1f);
    wr(`ICSD_A_STATUS, 8'hff);
    rd(`ICSD_A_STATUS, 8'h40);
    wr(12'h100, 8'hff);
    rd(12'h100, 8'h00);
    // A write while the clock enable is low must be lost.
    @(posedge core_clk_in) clk_en_in <= 1'b0;
    wr(`ICSD_A_POWER, 8'h00);
    @(posedge core_clk_in) clk_en_in <= 1'b1;
    rd(`ICSD_A_POWER, 8'h03);
    wr(`ICSD_A_POWER, 8'h01);
    chk(out_divider_route_out, 8'h01);
    // Automatic revertive choice by rank, ties and alarms.
    wr(`ICSD_A_HOLD, 8'h00);
    wr(`ICSD_A_MASKS, 8'h00);
    wr(`ICSD_A_RANKS, 8'h12);
    wr(`ICSD_A_SWITCH, 8'h02);
    sel(1'b1, 1'b0);
    wr(`ICSD_A_RANKS, 8'h11);
    sel(1'b0, 1'b0);
    wr(`ICSD_A_RANKS, 8'h21);
    al(2'b01, 2'b00);
    sel(1'b1, 1'b0);
    al(2'b00, 2'b00);
    sel(1'b0, 1'b0);
    // Non-revertive mode, masks, holdover and reserved ranks.
    wr(`ICSD_A_SWITCH, 8'h01);
    al(2'b00, 2'b01);
    sel(1'b1, 1'b0);
    al(2'b00, 2'b00);
    sel(1'b1, 1'b0);
    wr(`ICSD_A_MASKS, 8'h02);
    al(2'b10, 2'b00);
    sel(1'b1, 1'b0);
    al(2'b10, 2'b10);
    sel(1'b0, 1'b0);
    al(2'b11, 2'b11);
    sel(1'b0, 1'b1);
    al(2'b00, 2'b00);
    sel(1'b0, 1'b0);
    wr(`ICSD_A_RANKS, 8'h10);
    sel(1'b1, 1'b0);
    wr(`ICSD_A_RANKS, 8'h31);
    sel(1'b0, 1'b0);
    wr(`ICSD_A_HOLD, 8'h01);
    sel(1'b0, 1'b1);
    // Manual mode from the pin and from the register bit.
    wr(`ICSD_A_HOLD, 8'h00);
    wr(`ICSD_A_SWITCH, 8'h00);
    wr(`ICSD_A_SEL, 8'h00);
    @(posedge core_clk_in) pin_select_in <= 1'b1;
    sel(1'b1, 1'b0);
    rd(`ICSD_A_STATUS, 8'h40);
    wr(`ICSD_A_SEL, 8'h01);
    sel(1'b0, 1'b0);
    rd(`ICSD_A_STATUS, 8'h00);
    al(2'b11, 2'b11);
    wr(`ICSD_A_SEL, 8'h03);
    sel(1'b1, 1'b0);
    results();
  end
endmodule

bind icsd_ctl icsd_chk chk_u (.core_clk_in, .rst_n_in, .clk_en_in,
  .reg_wr_in, .reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .holdover_out, .hitless_enable_out, .input_buf_en_out, .pulsed_cmos_out,
  .out_divider_route_out, .out_divider_power_out,
  .pre_divider_clk_off_out);
